// file: rtl/hvdp_bank.sv
// Overview of operation
// - Per-unit user setpoint is write-only, a 2-byte float from -15 to 60 degrees.
// - Per-unit unit setpoint is read-only, 2-byte float, -15 to 60 degrees.
// - Unit ambient temperature is read-only, 2-byte float, -35 to 92 degrees.
// - With user setpoint and user room both in use, unit follows only those.
// - Fan speed is an 8-bit read/write code: 0 auto, 1 low, 2 middle, 3 high.
// - Four one-hot fan flags per unit, all published on any fan change.
// - Louver is 8-bit read/write: 0 auto, 1 horizontal, 2-4 positions, 5 vertical, swing.
// - Filter alarm bit is read-only; writing one to reset clears it, reset reads zero.
// - Unit fault is a read-only 16-bit code, zero meaning no error.
// - Five read/write per-unit remote lock bits, one locks and zero unlocks.
// - Two read-only link fault codes: 0 fine, 256 no communication, else error.
// - Central write-only power object switches every unit, 0 off and 1 on.
// - Central write-only mode: 0 cooling, 1 heating, for all units.
// - Central write-only setpoint, integer degrees -15 to 60, for all units.
// - Central write-only fan speed code 0 to 3 applied to all units.
// - Five central write-only lock bits applied to all units.
// - A value changed from the unit side is sent out as a write telegram.
`timescale 1ns/100ps
`default_nettype none
module hvdp_bank import hvdp_pkg::*; #(
  parameter int NUM_UNITS = NUM_UNITS_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 iu_valid,
  input  wire logic [$clog2(NUM_UNITS)-1:0] iu_unit,
  input  wire hvdp_field_t          iu_field,
  input  wire logic [15:0]          iu_data,
  input  wire logic [15:0]          first_link_fault,
  input  wire logic [15:0]          second_link_fault,
  output logic                      cmd_valid,
  output logic                      cmd_all,
  output logic [$clog2(NUM_UNITS)-1:0] cmd_unit,
  output hvdp_field_t               cmd_kind,
  output logic [15:0]               cmd_data,
  output logic                      tx_valid,
  output logic                      tx_all,
  output logic [$clog2(NUM_UNITS)-1:0] tx_unit,
  output hvdp_field_t               tx_field,
  output logic [15:0]               tx_data,
  output logic [NUM_UNITS-1:0]      unit_follows_user,
  output logic                      irq
);
  localparam int UW = $clog2(NUM_UNITS);

  // Unit indices address the arrays directly, so the count must be a power of two.
  if (NUM_UNITS < 2 || NUM_UNITS > 128 || (1 << UW) != NUM_UNITS) begin : g_bad_units
    $error("NUM_UNITS must be a power of two from 2 to 128");
  end

  logic [1:0] rs_q;
  logic       rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rs_q <= 2'b00;
    else rs_q <= {rs_q[0], 1'b1};
  end
  assign rst_sync_b = rs_q[1];

  logic              aw_held_r, w_held_r, ar_held_r;
  logic [7:0]        awaddr_q, araddr_q;
  logic [31:0]       wdata_q;
  logic [UW-1:0]     unit_sel_r;
  logic [15:0]       sp_unit_r [NUM_UNITS];
  logic [15:0]       rt_unit_r [NUM_UNITS];
  logic [15:0]       fault_r   [NUM_UNITS];
  logic [7:0]        louver_r  [NUM_UNITS];
  logic [4:0]        locks_r   [NUM_UNITS];
  logic [1:0]        fan_r     [NUM_UNITS];
  logic [NUM_UNITS-1:0] filt_r, sp_used_r, rt_used_r;
  logic [15:0]       lf1_r, lf2_r;
  logic              fan_pend_r, fan_pend_all_r;
  logic [UW-1:0]     fan_pend_unit_r;
  logic [1:0]        fan_pend_code_r;
  logic [STS_W-1:0]  sts_r, mask_r;

  wire        aw_take = s_axi_awvalid & s_axi_awready;
  wire        w_take  = s_axi_wvalid & s_axi_wready;
  wire        ar_take = s_axi_arvalid & s_axi_arready;
  wire        wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire [31:0] strb_m  = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [15:0] wd      = wdata_q[15:0];
  wire [7:0]  ofs     = awaddr_q;
  wire [UW-1:0] su    = unit_sel_r;

  wire [15:0] usp_cl  = knx_clamp(wd, SP_LO_F, SP_HI_F, SP_LO_C, SP_HI_C);
  wire [15:0] urt_cl  = knx_clamp(wd, RT_LO_F, RT_HI_F, RT_LO_C, RT_HI_C);
  wire signed [31:0] asp_c = knx_centi(wd);
  wire        asp_ok  = asp_c >= SP_LO_C && asp_c <= SP_HI_C && (asp_c % CENTI_PER_DEG) == 0;
  wire        fan_ok  = wd[7:0] <= FAN_MAX;
  wire        lvr_ok  = wd[7:0] <= LOUVER_SWING;
  wire        mode_ok = wd[7:0] <= MODE_MAX;
  wire        is_all  = ofs inside {OFS_ALL_POWER, OFS_ALL_MODE, OFS_ALL_SP, OFS_ALL_FAN, OFS_ALL_LOCKS};

  wire wr_hit = is_all || ofs inside {OFS_UNIT_SEL, OFS_USER_SP, OFS_UNIT_SP, OFS_USER_ROOM, OFS_UNIT_ROOM,
                OFS_FAN, OFS_FAN_FLAGS, OFS_LOUVER, OFS_FILTER, OFS_FAULT, OFS_LOCKS, OFS_LINK,
                OFS_IRQ_STS, OFS_IRQ_MASK};
  wire rd_hit = araddr_q inside {OFS_UNIT_SEL, OFS_USER_SP, OFS_UNIT_SP, OFS_USER_ROOM, OFS_UNIT_ROOM,
                OFS_FAN, OFS_FAN_FLAGS, OFS_LOUVER, OFS_FILTER, OFS_FAULT, OFS_LOCKS, OFS_LINK,
                OFS_ALL_POWER, OFS_ALL_MODE, OFS_ALL_SP, OFS_ALL_FAN, OFS_ALL_LOCKS, OFS_IRQ_STS, OFS_IRQ_MASK};

  // Write-only objects and the filter reset bit read back as zero.
  wire [31:0] rd_word =
    (araddr_q == OFS_UNIT_SEL)  ? {{(32-UW){1'b0}}, su} :
    (araddr_q == OFS_UNIT_SP)   ? {16'h0000, sp_unit_r[su]} :
    (araddr_q == OFS_UNIT_ROOM) ? {16'h0000, rt_unit_r[su]} :
    (araddr_q == OFS_FAN)       ? {30'h0000_0000, fan_r[su]} :
    (araddr_q == OFS_FAN_FLAGS) ? {28'h000_0000, 4'h1 << fan_r[su]} :
    (araddr_q == OFS_LOUVER)    ? {24'h00_0000, louver_r[su]} :
    (araddr_q == OFS_FILTER)    ? {31'h0000_0000, filt_r[su]} :
    (araddr_q == OFS_FAULT)     ? {16'h0000, fault_r[su]} :
    (araddr_q == OFS_LOCKS)     ? {27'h000_0000, locks_r[su]} :
    (araddr_q == OFS_LINK)      ? {lf2_r, lf1_r} :
    (araddr_q == OFS_IRQ_STS)   ? {27'h000_0000, sts_r} :
    (araddr_q == OFS_IRQ_MASK)  ? {27'h000_0000, mask_r} : 32'h0000_0000;

  wire wr_ok =
    (ofs inside {OFS_USER_SP, OFS_USER_ROOM, OFS_LOCKS, OFS_ALL_POWER, OFS_ALL_LOCKS}) ||
    (ofs inside {OFS_FAN, OFS_ALL_FAN} && fan_ok) ||
    (ofs == OFS_LOUVER && lvr_ok) ||
    (ofs == OFS_FILTER && wd[1]) ||
    (ofs == OFS_ALL_MODE && mode_ok) ||
    (ofs == OFS_ALL_SP && asp_ok);
  wire wr_bad = wr_fire && ((ofs == OFS_USER_SP && usp_cl != wd) || (ofs == OFS_USER_ROOM && urt_cl != wd) ||
                (ofs inside {OFS_FAN, OFS_ALL_FAN, OFS_LOUVER, OFS_ALL_MODE, OFS_ALL_SP} && !wr_ok));
  wire hvdp_field_t wr_kind =
    (ofs == OFS_USER_SP)   ? F_SETPOINT : (ofs == OFS_USER_ROOM) ? F_ROOM :
    (ofs inside {OFS_FAN, OFS_ALL_FAN}) ? F_FAN : (ofs == OFS_LOUVER) ? F_LOUVER :
    (ofs == OFS_FILTER)    ? F_FILTER : (ofs == OFS_ALL_POWER) ? F_POWER :
    (ofs == OFS_ALL_MODE)  ? F_MODE : (ofs == OFS_ALL_SP) ? F_ALLSP : F_LOCKS;
  wire [15:0] wr_cdata = (ofs == OFS_USER_SP) ? usp_cl : (ofs == OFS_USER_ROOM) ? urt_cl : wd;

  wire [15:0] iu_new =
    (iu_field == F_SETPOINT) ? knx_clamp(iu_data, SP_LO_F, SP_HI_F, SP_LO_C, SP_HI_C) :
    (iu_field == F_ROOM)     ? knx_clamp(iu_data, RT_LO_F, RT_HI_F, RT_LO_C, RT_HI_C) :
    (iu_field == F_FAN)      ? {14'h0000, iu_data[1:0]} :
    (iu_field == F_LOUVER)   ? {8'h00, iu_data[7:0]} :
    (iu_field == F_FILTER)   ? {15'h0000, iu_data[0]} : iu_data;
  wire [15:0] iu_old =
    (iu_field == F_SETPOINT) ? sp_unit_r[iu_unit] : (iu_field == F_ROOM) ? rt_unit_r[iu_unit] :
    (iu_field == F_FAN)      ? {14'h0000, fan_r[iu_unit]} : (iu_field == F_LOUVER) ? {8'h00, louver_r[iu_unit]} :
    (iu_field == F_FILTER)   ? {15'h0000, filt_r[iu_unit]} : (iu_field == F_FAULT) ? fault_r[iu_unit] : iu_new;
  wire        iu_chg  = iu_valid && iu_new != iu_old;
  wire [15:0] iu_txd  = (iu_field == F_FAN) ? {10'h000, 4'h1 << iu_new[1:0], iu_new[1:0]} : iu_new;
  wire        lf1_chg = first_link_fault != lf1_r;
  wire        lf2_chg = second_link_fault != lf2_r;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      {aw_held_r, w_held_r, s_axi_awready, s_axi_wready, s_axi_bvalid} <= 5'h00;
      awaddr_q    <= 8'h00;
      wdata_q     <= 32'h0000_0000;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_take) {aw_held_r, awaddr_q} <= {1'b1, s_axi_awaddr};
      if (w_take) {w_held_r, wdata_q} <= {1'b1, s_axi_wdata & strb_m};
      s_axi_awready <= ~(aw_held_r | aw_take) & ~s_axi_bvalid;
      s_axi_wready  <= ~(w_held_r | w_take) & ~s_axi_bvalid;
      if (wr_fire) begin
        {aw_held_r, w_held_r, s_axi_bvalid} <= 3'b001;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      {ar_held_r, s_axi_arready, s_axi_rvalid} <= 3'b000;
      araddr_q    <= 8'h00;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (ar_take) {ar_held_r, araddr_q} <= {1'b1, s_axi_araddr};
      s_axi_arready <= ~(ar_held_r | ar_take) & ~s_axi_rvalid;
      if (ar_held_r && !s_axi_rvalid) begin
        {ar_held_r, s_axi_rvalid} <= 2'b01;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // Unit-side updates are applied after bus writes, so the unit wins a same-cycle race.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      unit_sel_r <= '0;
      {filt_r, sp_used_r, rt_used_r} <= '0;
      for (int i = 0; i < NUM_UNITS; i++) begin
        {sp_unit_r[i], rt_unit_r[i], fault_r[i]} <= 48'h0000_0000_0000;
        {louver_r[i], locks_r[i], fan_r[i]} <= 15'h0000;
      end
    end else begin
      if (wr_fire) begin
        case (ofs)
          OFS_UNIT_SEL:  unit_sel_r <= wd[UW-1:0];
          OFS_USER_SP:   sp_used_r[su] <= 1'b1;
          OFS_USER_ROOM: rt_used_r[su] <= 1'b1;
          OFS_FAN:       if (fan_ok) fan_r[su] <= wd[1:0];
          OFS_LOUVER:    if (lvr_ok) louver_r[su] <= wd[7:0];
          OFS_FILTER:    if (wd[1]) filt_r[su] <= 1'b0;
          OFS_LOCKS:     locks_r[su] <= wd[4:0];
          OFS_ALL_FAN:   for (int i = 0; i < NUM_UNITS; i++) if (fan_ok) fan_r[i] <= wd[1:0];
          OFS_ALL_LOCKS: for (int i = 0; i < NUM_UNITS; i++) locks_r[i] <= wd[4:0];
          default: ;
        endcase
      end
      if (iu_valid) begin
        case (iu_field)
          F_SETPOINT: sp_unit_r[iu_unit] <= iu_new;
          F_ROOM:     rt_unit_r[iu_unit] <= iu_new;
          F_FAN:      fan_r[iu_unit] <= iu_new[1:0];
          F_LOUVER:   louver_r[iu_unit] <= iu_new[7:0];
          F_FILTER:   filt_r[iu_unit] <= iu_new[0];
          F_FAULT:    fault_r[iu_unit] <= iu_new;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      {cmd_valid, cmd_all} <= 2'b00;
      cmd_unit <= '0;
      cmd_kind <= F_SETPOINT;
      cmd_data <= 16'h0000;
    end else begin
      cmd_valid <= wr_fire && wr_ok;
      if (wr_fire && wr_ok) begin
        cmd_all  <= is_all;
        cmd_unit <= su;
        cmd_kind <= wr_kind;
        cmd_data <= wr_cdata;
      end
    end
  end

  // One telegram per cycle; fan publications from bus writes wait behind unit changes.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      {tx_valid, tx_all, fan_pend_r, fan_pend_all_r} <= 4'h0;
      {tx_unit, fan_pend_unit_r} <= '0;
      tx_field <= F_SETPOINT;
      {tx_data, lf1_r, lf2_r} <= 48'h0000_0000_0000;
      fan_pend_code_r <= 2'b00;
    end else begin
      tx_valid <= iu_chg || fan_pend_r || lf1_chg || lf2_chg;
      if (iu_chg) begin
        {tx_all, tx_unit, tx_field, tx_data} <= {1'b0, iu_unit, iu_field, iu_txd};
      end else if (fan_pend_r) begin
        fan_pend_r <= 1'b0;
        {tx_all, tx_unit, tx_field} <= {fan_pend_all_r, fan_pend_unit_r, F_FAN};
        tx_data <= {10'h000, 4'h1 << fan_pend_code_r, fan_pend_code_r};
      end else if (lf1_chg) begin
        lf1_r <= first_link_fault;
        {tx_all, tx_field, tx_data} <= {1'b1, F_LINK1, first_link_fault};
      end else if (lf2_chg) begin
        lf2_r <= second_link_fault;
        {tx_all, tx_field, tx_data} <= {1'b1, F_LINK2, second_link_fault};
      end
      if (wr_fire && fan_ok && ((ofs == OFS_FAN && wd[1:0] != fan_r[su]) || ofs == OFS_ALL_FAN)) begin
        {fan_pend_r, fan_pend_all_r} <= {1'b1, ofs == OFS_ALL_FAN};
        fan_pend_unit_r <= su;
        fan_pend_code_r <= wd[1:0];
      end
    end
  end

  wire [STS_W-1:0] sts_set = {wr_bad, (!iu_chg && !fan_pend_r && (lf1_chg || lf2_chg)),
                              (iu_chg && iu_field == F_FAULT && iu_new != 16'h0000),
                              (iu_chg && iu_field == F_FILTER && iu_new[0]),
                              (iu_chg || fan_pend_r || lf1_chg || lf2_chg)};
  wire [STS_W-1:0] sts_clr = (wr_fire && ofs == OFS_IRQ_STS) ? wd[STS_W-1:0] : '0;

  // Set is ORed after the clear so an event in the clearing cycle is kept.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      {sts_r, mask_r} <= '0;
      irq <= 1'b0;
    end else begin
      sts_r <= (sts_r & ~sts_clr) | sts_set;
      if (wr_fire && ofs == OFS_IRQ_MASK) mask_r <= wd[STS_W-1:0];
      irq <= |(sts_r & mask_r);
    end
  end

  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_follow
    always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) unit_follows_user[u] <= 1'b0;
      else unit_follows_user[u] <= sp_used_r[u] & rt_used_r[u];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  sequence s_wr(logic [7:0] o);
    wr_fire && ofs == o;
  endsequence
  sequence s_cmd(hvdp_field_t k);
    cmd_valid && cmd_kind == k;
  endsequence
  sequence s_iu(hvdp_field_t k);
    iu_chg && iu_field == k;
  endsequence

  property p_usp;
    s_wr(OFS_USER_SP) |=> s_cmd(F_SETPOINT) ##0 (knx_centi(cmd_data) >= SP_LO_C && knx_centi(cmd_data) <= SP_HI_C);
  endproperty
  a_usp: assert property (p_usp) else $error("user setpoint forwarded out of range");
  property p_sp_rpt;
    s_iu(F_SETPOINT) |=> tx_valid && tx_field == F_SETPOINT && knx_centi(tx_data) <= SP_HI_C;
  endproperty
  a_sp_rpt: assert property (p_sp_rpt) else $error("unit setpoint report wrong");
  property p_room_rpt;
    s_iu(F_ROOM) |=> tx_valid && knx_centi(tx_data) >= RT_LO_C && knx_centi(tx_data) <= RT_HI_C;
  endproperty
  a_room_rpt: assert property (p_room_rpt) else $error("ambient report out of range");
  property p_follow;
    unit_follows_user == $past(sp_used_r & rt_used_r);
  endproperty
  a_follow: assert property (p_follow) else $error("follow-user flags wrong");
  property p_fan_code;
    s_wr(OFS_FAN) ##0 wd[7:0] > FAN_MAX |=> !cmd_valid;
  endproperty
  a_fan_code: assert property (p_fan_code) else $error("bad fan code accepted");
  property p_fan_pub;
    s_iu(F_FAN) |=> tx_valid && tx_field == F_FAN && tx_data[5:2] == (4'h1 << tx_data[1:0]);
  endproperty
  a_fan_pub: assert property (p_fan_pub) else $error("fan flags not published");
  property p_louver;
    s_wr(OFS_LOUVER) ##0 wd[7:0] > LOUVER_SWING |=> !cmd_valid ##1 !cmd_valid;
  endproperty
  a_louver: assert property (p_louver) else $error("bad louver code accepted");
  property p_filt_rd;
    s_axi_rvalid && araddr_q == OFS_FILTER |-> !s_axi_rdata[1];
  endproperty
  a_filt_rd: assert property (p_filt_rd) else $error("filter reset bit reads one");
  property p_filt_clr;
    s_wr(OFS_FILTER) ##0 (wd[1] && !(iu_valid && iu_field == F_FILTER)) |=> !filt_r[$past(unit_sel_r)];
  endproperty
  a_filt_clr: assert property (p_filt_clr) else $error("filter alarm not cleared");
  property p_fault;
    s_iu(F_FAULT) |=> tx_valid && tx_data == $past(iu_data);
  endproperty
  a_fault: assert property (p_fault) else $error("fault code not reported");
  property p_lock;
    s_wr(OFS_LOCKS) |=> locks_r[$past(unit_sel_r)] == $past(wdata_q[4:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("unit lock bits not stored");
  property p_link;
    lf1_chg && !iu_chg && !fan_pend_r |=> tx_valid && tx_field == F_LINK1 && tx_data == lf1_r;
  endproperty
  a_link: assert property (p_link) else $error("link fault not reported");
  property p_power;
    s_wr(OFS_ALL_POWER) |=> s_cmd(F_POWER) ##0 (cmd_all && cmd_data[0] == $past(wdata_q[0]));
  endproperty
  a_power: assert property (p_power) else $error("central power not sent");
  property p_mode;
    s_cmd(F_MODE) |-> cmd_all && cmd_data[7:0] <= MODE_MAX;
  endproperty
  a_mode: assert property (p_mode) else $error("central mode out of code");
  property p_allsp;
    s_cmd(F_ALLSP) |-> (knx_centi(cmd_data) % CENTI_PER_DEG) == 0 && knx_centi(cmd_data) >= SP_LO_C;
  endproperty
  a_allsp: assert property (p_allsp) else $error("central setpoint not integer in range");
  property p_allfan;
    s_wr(OFS_ALL_FAN) ##0 (fan_ok && !(iu_valid && iu_field == F_FAN)) |=> fan_r[0] == $past(wdata_q[1:0]);
  endproperty
  a_allfan: assert property (p_allfan) else $error("central fan not applied");
  property p_alllock;
    s_wr(OFS_ALL_LOCKS) |=> locks_r[NUM_UNITS-1] == $past(wdata_q[4:0]);
  endproperty
  a_alllock: assert property (p_alllock) else $error("central locks not applied");
  property p_tx;
    iu_chg |=> tx_valid && tx_unit == $past(iu_unit) && !tx_all;
  endproperty
  a_tx: assert property (p_tx) else $error("unit change not sent");
  property p_reject;
    s_wr(OFS_ALL_SP) ##0 !asp_ok |=> !cmd_valid && sts_r[STS_REJECT];
  endproperty
  a_reject: assert property (p_reject) else $error("bad central setpoint forwarded");
endmodule : hvdp_bank
`default_nettype wire

// file: shared/hvdp_pkg.sv
`default_nettype none
package hvdp_pkg;
  localparam int NUM_UNITS_DEF = 64;

  localparam logic [7:0] OFS_UNIT_SEL  = 8'h00;
  localparam logic [7:0] OFS_USER_SP   = 8'h04;
  localparam logic [7:0] OFS_UNIT_SP   = 8'h08;
  localparam logic [7:0] OFS_USER_ROOM = 8'h0C;
  localparam logic [7:0] OFS_UNIT_ROOM = 8'h10;
  localparam logic [7:0] OFS_FAN       = 8'h14;
  localparam logic [7:0] OFS_FAN_FLAGS = 8'h18;
  localparam logic [7:0] OFS_LOUVER    = 8'h1C;
  localparam logic [7:0] OFS_FILTER    = 8'h20;
  localparam logic [7:0] OFS_FAULT     = 8'h24;
  localparam logic [7:0] OFS_LOCKS     = 8'h28;
  localparam logic [7:0] OFS_LINK      = 8'h2C;
  localparam logic [7:0] OFS_ALL_POWER = 8'h30;
  localparam logic [7:0] OFS_ALL_MODE  = 8'h34;
  localparam logic [7:0] OFS_ALL_SP    = 8'h38;
  localparam logic [7:0] OFS_ALL_FAN   = 8'h3C;
  localparam logic [7:0] OFS_ALL_LOCKS = 8'h40;
  localparam logic [7:0] OFS_IRQ_STS   = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h48;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Range limits as 2-byte floats and in hundredths of a degree.
  localparam logic [15:0] SP_LO_F = 16'h8224;
  localparam logic [15:0] SP_HI_F = 16'h15DC;
  localparam logic [15:0] RT_LO_F = 16'h892A;
  localparam logic [15:0] RT_HI_F = 16'h1C7E;
  localparam int SP_LO_C = -1500;
  localparam int SP_HI_C = 6000;
  localparam int RT_LO_C = -3500;
  localparam int RT_HI_C = 9200;
  localparam int CENTI_PER_DEG = 100;

  localparam logic [7:0] FAN_MAX      = 8'h03;
  localparam logic [7:0] LOUVER_SWING = 8'h06;
  localparam logic [7:0] MODE_MAX     = 8'h01;

  localparam int STS_TX     = 0;
  localparam int STS_FILTER = 1;
  localparam int STS_FAULT  = 2;
  localparam int STS_LINK   = 3;
  localparam int STS_REJECT = 4;
  localparam int STS_W      = 5;

  typedef enum logic [3:0] {
    F_SETPOINT, F_ROOM, F_FAN, F_LOUVER, F_FILTER, F_FAULT, F_LOCKS,
    F_LINK1, F_LINK2, F_POWER, F_MODE, F_ALLSP
  } hvdp_field_t;

  function automatic logic signed [31:0] knx_centi(input logic [15:0] f);
    logic signed [31:0] m;
    m = {{20{f[15]}}, f[15], f[10:0]};
    return m <<< f[14:11];
  endfunction : knx_centi

  function automatic logic [15:0] knx_clamp(input logic [15:0] f, input logic [15:0] lo_f,
                                            input logic [15:0] hi_f, input int lo_c, input int hi_c);
    logic signed [31:0] c;
    c = knx_centi(f);
    return (c < lo_c) ? lo_f : (c > hi_c) ? hi_f : f;
  endfunction : knx_clamp
endpackage : hvdp_pkg
`default_nettype wire

// file: verif/hvdp_unit_model.sv
`timescale 1ns/100ps
`default_nettype none
module hvdp_unit_model import hvdp_pkg::*; (
  input  wire logic  clk,
  output logic       iu_valid,
  output logic [1:0] iu_unit,
  output hvdp_field_t iu_field,
  output logic [15:0] iu_data,
  output logic [15:0] first_link_fault,
  output logic [15:0] second_link_fault
);
  initial begin
    iu_valid = 1'b0;
    iu_unit = 2'h0;
    iu_field = F_FAULT;
    iu_data = 16'h0000;
    first_link_fault = 16'h0000;
    second_link_fault = 16'h0100;
  end
  // Data is inverted after the pulse so a stale value can never pass.
  task automatic report(input hvdp_field_t f, input logic [15:0] d);
    @(posedge clk);
    iu_field <= f;
    iu_data <= d;
    iu_valid <= 1'b1;
    @(posedge clk);
    iu_valid <= 1'b0;
    iu_data <= ~d;
  endtask : report
endmodule : hvdp_unit_model
`default_nettype wire

// file: verif/tb_hvdp_bank.sv
`timescale 1ns/100ps
`default_nettype none
module tb_hvdp_bank import hvdp_pkg::*;;
  logic clk, rst_b, awv, wv, br, arv, rr, awr, wr, bv, arr, rv, irq, iuv;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] bresp, rresp, iuu;
  logic [15:0] iud, l1, l2;
  logic [3:0] ufu;
  hvdp_field_t iuf;
  int miscompares = 0, tests_run = 0, cyc = 0;
  hvdp_bank #(.NUM_UNITS(4)) dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .iu_valid(iuv), .iu_unit(iuu), .iu_field(iuf), .iu_data(iud), .first_link_fault(l1),
    .second_link_fault(l2), .cmd_valid(), .cmd_all(), .cmd_unit(), .cmd_kind(), .cmd_data(), .tx_valid(),
    .tx_all(), .tx_unit(), .tx_field(), .tx_data(), .unit_follows_user(ufu), .irq(irq));
  hvdp_unit_model um (.clk(clk), .iu_valid(iuv), .iu_unit(iuu), .iu_field(iuf), .iu_data(iud),
    .first_link_fault(l1), .second_link_fault(l2));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    chk(bresp, RESP_OKAY);
  endtask : wr32
  task automatic rd32(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    chk(rd, e);
    chk(rresp, er);
  endtask : rd32
  // Central objects, sensor room writes and unit reports; status bits 0, 2, 3 and 4 are left over from earlier tests.
  task automatic central_and_room;
    wr32(OFS_USER_ROOM, 32'h0000_1FFF);
    rd32(OFS_IRQ_STS, 32'h0000_001D);
    wr32(OFS_IRQ_STS, 32'h0000_001F);
    wr32(OFS_ALL_SP, 32'h0000_0001);
    rd32(OFS_IRQ_STS, 32'h0000_0010);
    wr32(OFS_USER_SP, 32'h0000_15DC);
    repeat (2) @(posedge clk);
    chk(ufu, 32'h0000_0001);
    wr32(OFS_ALL_MODE, 32'h0000_0001);
    wr32(OFS_ALL_POWER, 32'h0000_0001);
    wr32(OFS_ALL_FAN, 32'h0000_0003);
    rd32(OFS_FAN, 32'h0000_0003);
    wr32(OFS_ALL_LOCKS, 32'h0000_000A);
    rd32(OFS_LOCKS, 32'h0000_000A);
    um.report(F_SETPOINT, 16'h7FFF);
    um.report(F_FAN, 16'h0001);
    repeat (2) @(posedge clk);
    rd32(OFS_UNIT_SP, {16'h0000, SP_HI_F});
    rd32(OFS_FAN_FLAGS, 32'h0000_0002);
    $display("central and room test done");
  endtask : central_and_room
  task automatic conclude;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    rst_b = 1'b0; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0; awa = 8'h00; ara = 8'h00; wd = 32'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd32(OFS_FAN, 32'h0);
    rd32(OFS_LOCKS, 32'h0);
    $display("reset test done");
    wr32(OFS_FAN, 32'h2);
    rd32(OFS_FAN, 32'h2);
    rd32(OFS_FAN_FLAGS, 32'h4);
    wr32(OFS_FAN, 32'h5);
    rd32(OFS_FAN, 32'h2);
    wr32(OFS_LOUVER, 32'h5);
    rd32(OFS_LOUVER, 32'h5);
    $display("fan and louver test done");
    wr32(OFS_IRQ_MASK, 32'h2);
    um.report(F_FILTER, 16'h0001);
    repeat (2) @(posedge clk);
    rd32(OFS_FILTER, 32'h1);
    chk(irq, 1'b1);
    wr32(OFS_FILTER, 32'h2);
    rd32(OFS_FILTER, 32'h0);
    wr32(OFS_IRQ_STS, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("filter and interrupt test done");
    um.report(F_FAULT, 16'h0012);
    repeat (2) @(posedge clk);
    rd32(OFS_FAULT, 32'h12);
    rd32(OFS_LINK, 32'h0100_0000);
    wr32(OFS_LOCKS, 32'h15);
    rd32(OFS_LOCKS, 32'h15);
    rd32(OFS_USER_SP, 32'h0);
    rd32(8'h4C, 32'h0, RESP_SLVERR);
    $display("status and access test done");
    central_and_room;
    conclude;
  end
endmodule : tb_hvdp_bank
`default_nettype wire
